//--- core/bbx_addr_gen.sv
/*
 * File operand address generator: access bank, banked RAM or indexed
 * literal offset. Purely combinational; the caller registers the result.
 */
module bbx_addr_gen (
    input  wire logic [7:0]  file_i,      // 8-bit file field
    input  wire logic        acc_i,       // Access bit
    input  wire logic [3:0]  bank_i,      // Bank select pointer
    input  wire logic        ext_en_i,    // Extended set enabled
    input  wire logic [11:0] index_i,     // Index base for offset mode
    output logic      [11:0] addr_o,      // Resolved address
    output logic             indexed_o    // Indexed mode used
);

    always_comb begin
        indexed_o = ext_en_i && !acc_i && (file_i <= bbx_pkg::BBX_IDX_LIMIT);
        if (indexed_o) begin
            addr_o = index_i + {4'h0, file_i};
        end else if (acc_i) begin
            addr_o = {bank_i, file_i};
        end else if (file_i < bbx_pkg::BBX_ACC_SPLIT) begin
            addr_o = {bbx_pkg::BBX_BANK_LO, file_i};
        end else begin
            addr_o = {bbx_pkg::BBX_BANK_HI, file_i};
        end
    end

endmodule

//--- core/bbx_exec.sv
/*
 * Execution unit for the relative jump, single-bit force-to-one and the
 * two bit-test-and-skip instructions. Steps through Q1..Q4 per cycle.
 * Assumes the fetch unit presents the prefetched word on instr_i and
 * holds it stable for a whole instruction cycle; memory read data
 * arrives combinationally on the same clock.
 */
// What this block does
// - new PC is PC plus two plus 2n
// - jump opcode is 1101 then zero
// - jump takes two cycles, second flushed
// - force selected file bit to one only
// - access bit picks access bank or banked
// - indexed offset when extended, a zero, f<=95
// - skip next when tested bit is clear
// - skip next when tested bit is set
// - skipped instruction replaced by no-operation
module bbx_exec (
    input  wire logic             core_clk_i,   // 125 MHz core clock
    input  wire logic             rstn_i,       // Async reset, active low
    input  wire logic [15:0]      instr_i,      // Prefetched word
    input  wire logic [3:0]       bank_i,       // Bank select pointer
    input  wire logic             ext_en_i,     // Extended set enabled
    input  wire logic [11:0]      index_i,      // Index base register
    input  wire logic [7:0]       mem_rdata_i,  // File read data
    output bbx_pkg::bbx_mem_t     mem_o,        // File access request
    output logic [20:0]           pc_o,         // Program counter
    output logic [3:0]            quarter_o,    // One-hot quarter
    output logic                  cycle_end_o,  // Last quarter pulse
    output logic                  flush_o,      // Current cycle is a nop
    output logic                  skip_o,       // Skip taken this cycle
    output logic                  jump_o,       // Jump taken this cycle
    output logic                  indexed_o,    // Offset mode in use
    output logic                  status_we_o   // Status flag write
);

    bbx_pkg::bbx_quarter_t q_reg;
    bbx_pkg::bbx_iclass_t  cls_reg;
    logic [20:0]           pc_reg;
    logic                  flush_reg;
    logic [7:0]            data_reg;
    logic [11:0]           addr_reg;
    logic                  idx_reg;
    logic                  skip_reg;
    logic                  jump_reg;
    bbx_pkg::bbx_mem_t     mem_reg;
    logic [11:0]           addr_next;
    logic                  idx_next;
    logic [2:0]            bit_sel;
    bbx_pkg::bbx_iclass_t  cls_next;
    logic [7:0]            data_mod;
    logic                  skip_hit;

    // Decoding shared by the class register, the read strobe and the indexed flag
    function automatic bbx_pkg::bbx_iclass_t classify(input logic [15:0] w);
        bbx_pkg::bbx_iclass_t c;
        logic [3:0]           op;
        c  = bbx_pkg::BBX_I_OTHER;
        op = w[bbx_pkg::BBX_OP_MSB:bbx_pkg::BBX_OP_LSB];
        if (op == bbx_pkg::BBX_OP_JUMP_HI &&
            w[bbx_pkg::BBX_BIT_MSB] == bbx_pkg::BBX_OP_JUMP_B11) begin
            c = bbx_pkg::BBX_I_JUMP;
        end else if (op == bbx_pkg::BBX_OP_FORCE1) begin
            c = bbx_pkg::BBX_I_SET;
        end else if (op == bbx_pkg::BBX_OP_SKIP_CLR) begin
            c = bbx_pkg::BBX_I_TCLR;
        end else if (op == bbx_pkg::BBX_OP_SKIP_SET) begin
            c = bbx_pkg::BBX_I_TSET;
        end
        return c;
    endfunction

    // Only the file-register instructions touch data memory; a jump
    // takes its literal from the word itself, so it raises no strobe.
    function automatic logic is_file_op(input bbx_pkg::bbx_iclass_t c);
        return (c == bbx_pkg::BBX_I_SET) || (c == bbx_pkg::BBX_I_TCLR) ||
               (c == bbx_pkg::BBX_I_TSET);
    endfunction

    // Bit index field; instr_i is held for the whole cycle
    assign bit_sel = instr_i[bbx_pkg::BBX_BIT_MSB:bbx_pkg::BBX_BIT_LSB];

    // Next class: a flushed cycle decodes as a no-operation. The strobes
    // launched on the Q1 edge need it, since cls_reg only settles there.
    assign cls_next = flush_reg ? bbx_pkg::BBX_I_OTHER : classify(instr_i);

    // Operand with the selected bit forced; feeds both Q3 consumers
    assign data_mod = data_reg | (8'h01 << bit_sel);

    // Test outcome from the operand read in Q2
    assign skip_hit = (cls_reg == bbx_pkg::BBX_I_TCLR && !data_reg[bit_sel])
                   || (cls_reg == bbx_pkg::BBX_I_TSET && data_reg[bit_sel]);

    bbx_addr_gen u_addr (
        .file_i    (instr_i[bbx_pkg::BBX_FILE_MSB:0]),
        .acc_i     (instr_i[bbx_pkg::BBX_ACC_POS]),
        .bank_i    (bank_i),
        .ext_en_i  (ext_en_i),
        .index_i   (index_i),
        .addr_o    (addr_next),
        .indexed_o (idx_next)
    );

    // Quarter sequencer, Q1 to Q4 and around.
    // Reset parks it in Q1 so the first edge after release decodes.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_reg <= bbx_pkg::BBX_Q1;
        end else begin
            case (q_reg)
                bbx_pkg::BBX_Q1: q_reg <= bbx_pkg::BBX_Q2;
                bbx_pkg::BBX_Q2: q_reg <= bbx_pkg::BBX_Q3;
                bbx_pkg::BBX_Q3: q_reg <= bbx_pkg::BBX_Q4;
                bbx_pkg::BBX_Q4: q_reg <= bbx_pkg::BBX_Q1;
                default:         q_reg <= bbx_pkg::BBX_Q1;
            endcase
        end
    end

    // Q1 decode: class and operand address are latched once per cycle.
    // A flushed cycle decodes nothing, so the discarded word has no effect.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cls_reg  <= bbx_pkg::BBX_I_OTHER;
            addr_reg <= 12'h000;
            idx_reg  <= 1'b0;
        end else if (q_reg == bbx_pkg::BBX_Q1) begin
            cls_reg  <= cls_next;
            addr_reg <= addr_next;
            idx_reg  <= idx_next && is_file_op(cls_next);
        end
    end

    // Q2 read of the operand, Q3 modify for the force-one case
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_reg <= 8'h00;
        end else if (q_reg == bbx_pkg::BBX_Q2) begin
            data_reg <= mem_rdata_i;
        end else if (q_reg == bbx_pkg::BBX_Q3 &&
                     cls_reg == bbx_pkg::BBX_I_SET) begin
            data_reg <= data_mod;
        end
    end

    // Memory strobes are launched one edge ahead, so that the read is
    // seen during Q2 and the write back during Q4 (force-one only).
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_reg <= '0;
        end else begin
            mem_reg.addr  <= (q_reg == bbx_pkg::BBX_Q1) ? addr_next
                                                         : addr_reg;
            // The Q3 edge launches the modified byte with the write strobe
            mem_reg.wdata <= data_mod;
            mem_reg.rd    <= (q_reg == bbx_pkg::BBX_Q1) &&
                             is_file_op(cls_next);
            mem_reg.wr    <= (q_reg == bbx_pkg::BBX_Q3) &&
                             (cls_reg == bbx_pkg::BBX_I_SET);
        end
    end

    // Program counter: the fetch advance lands in Q4, the jump overrides it.
    // pc_reg holds this word's address; the step adds the fetch advance
    // of two, hence PC + 2 + 2n overall.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_reg   <= bbx_pkg::BBX_PC_RESET;
            jump_reg <= 1'b0;
        end else if (q_reg == bbx_pkg::BBX_Q4) begin
            jump_reg <= cls_reg == bbx_pkg::BBX_I_JUMP;
            if (cls_reg == bbx_pkg::BBX_I_JUMP) begin
                pc_reg <= pc_reg + jump_step(instr_i);
            end else begin
                pc_reg <= pc_reg + bbx_pkg::BBX_PC_STEP;
            end
        end
    end

    // Sign-extended doubled offset plus the fetch advance of two, -2046..+2048 bytes
    function automatic logic [20:0] jump_step(input logic [15:0] w);
        return {{9{w[bbx_pkg::BBX_OFS_MSB]}},
                w[bbx_pkg::BBX_OFS_MSB:0], 1'b0} + bbx_pkg::BBX_PC_STEP;
    endfunction

    // Skip decision sampled at Q4 from the value read in Q2
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            skip_reg  <= 1'b0;
            flush_reg <= 1'b0;
        end else if (q_reg == bbx_pkg::BBX_Q4) begin
            skip_reg  <= skip_hit;
            // refill after jump
            // A flushed cycle decodes as OTHER, so flush lasts one cycle
            flush_reg <= (cls_reg == bbx_pkg::BBX_I_JUMP) || skip_hit;
        end
    end

    // Outputs; no status write ever, since none of these touch flags
    // flags left unchanged
    assign status_we_o = 1'b0;
    assign mem_o       = mem_reg;
    assign pc_o        = pc_reg;
    assign quarter_o   = q_reg;
    assign cycle_end_o = q_reg == bbx_pkg::BBX_Q4;
    assign flush_o     = flush_reg;
    assign skip_o      = skip_reg;
    assign jump_o      = jump_reg;
    assign indexed_o   = idx_reg;

endmodule

//--- core/bbx_pkg.sv
/*
 * Shared constants and carrier types for the branch / bit-set / bit-test
 * execution block of an 8-bit core with a four-quarter instruction cycle.
 * Assumes a single 125 MHz clock and one quarter per clock edge.
 */
package bbx_pkg;

    // Quarter phases, one-hot
    typedef enum logic [3:0] {
        BBX_Q1 = 4'h1,
        BBX_Q2 = 4'h2,
        BBX_Q3 = 4'h4,
        BBX_Q4 = 4'h8
    } bbx_quarter_t;

    // Opcode patterns
    localparam logic [3:0] BBX_OP_JUMP_HI  = 4'hd;   // Top nibble 1101
    localparam logic       BBX_OP_JUMP_B11 = 1'h0;   // Bit 11 zero
    localparam logic [3:0] BBX_OP_FORCE1   = 4'h8;   // 1000
    localparam logic [3:0] BBX_OP_SKIP_CLR = 4'hb;   // 1011
    localparam logic [3:0] BBX_OP_SKIP_SET = 4'ha;   // 1010

    // Field positions in the 16-bit instruction word
    localparam int BBX_OP_MSB   = 15;
    localparam int BBX_OP_LSB   = 12;
    localparam int BBX_OFS_MSB  = 10;
    localparam int BBX_BIT_MSB  = 11;
    localparam int BBX_BIT_LSB  = 9;
    localparam int BBX_ACC_POS  = 8;
    localparam int BBX_FILE_MSB = 7;

    // Indexed literal offset window limit (95)
    localparam logic [7:0]  BBX_IDX_LIMIT = 8'h5f;
    // Access bank: offsets below 0x60 map to bank 0, the rest to SFR bank
    localparam logic [7:0]  BBX_ACC_SPLIT = 8'h60;
    localparam logic [3:0]  BBX_BANK_LO   = 4'h0;
    localparam logic [3:0]  BBX_BANK_HI   = 4'hf;
    localparam logic [20:0] BBX_PC_RESET  = 21'h0;
    localparam logic [20:0] BBX_PC_STEP   = 21'h2;

    // Decoded instruction class
    typedef enum logic [4:0] {
        BBX_I_OTHER = 5'h01,
        BBX_I_JUMP  = 5'h02,
        BBX_I_SET   = 5'h04,
        BBX_I_TCLR  = 5'h08,
        BBX_I_TSET  = 5'h10
    } bbx_iclass_t;

    // Data-memory access carrier
    typedef struct packed {
        logic        rd;     // Read strobe
        logic        wr;     // Write strobe
        logic [11:0] addr;   // Full data address
        logic [7:0]  wdata;  // Write data
    } bbx_mem_t;

endpackage

//--- tb/bbx_exec_properties.sv
/* Port-level checker for bbx_exec: quarter timing, jump target, bit
   force and skip results. Assumes one clock and async low reset. */
module bbx_exec_chk (
    input wire logic              core_clk_i,  // Core clock
    input wire logic              rstn_i,      // Async reset, low
    input wire logic [15:0]       instr_i,     // Instruction word
    input wire logic [3:0]        bank_i,      // Bank pointer
    input wire logic              ext_en_i,    // Extended set on
    input wire logic [11:0]       index_i,     // Index base
    input wire logic              indexed_o,   // Offset mode used
    input wire logic [7:0]        mem_rdata_i, // File read data
    input wire bbx_pkg::bbx_mem_t mem_o,       // File access
    input wire logic [20:0]       pc_o,        // Program counter
    input wire logic [3:0]        quarter_o,   // One-hot quarter
    input wire logic              flush_o,     // Flushed cycle
    input wire logic              skip_o,      // Skip taken
    input wire logic              jump_o,      // Jump taken
    input wire logic              status_we_o  // Status write
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [20:0] jofs;
    logic        go;
    // Doubled, sign-extended offset; go marks a live decode quarter
    assign jofs = {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
    assign go   = quarter_o == 4'h1 && !flush_o;
    jump_target_a:
        assert property (go && instr_i[15:11] == 5'h1a |-> ##4
            pc_o == $past(pc_o, 4) + 21'h2 + $past(jofs, 4))
        else $error("jump target wrong");
    jump_decode_a:
        assert property (go && instr_i[15:11] == 5'h1a |-> ##4
            jump_o && flush_o) else $error("jump not flagged");
    flush_len_a:
        assert property ($rose(flush_o) |-> flush_o [*4])
        else $error("flush shorter than a cycle");
    pc_q4_only_a:
        assert property ($changed(pc_o) |-> $past(quarter_o) == 4'h8)
        else $error("pc moved outside Q4");
    force_data_a:
        assert property (go && instr_i[15:12] == 4'h8 |-> ##3 mem_o.wr
            && mem_o.wdata == ($past(mem_rdata_i, 2)
            | (8'h01 << $past(instr_i[11:9], 3))))
        else $error("force write wrong");
    banked_addr_a:
        assert property (go && instr_i[15:12] == 4'h8 && instr_i[8] |=>
            mem_o.rd && mem_o.addr == {bank_i, instr_i[7:0]})
        else $error("banked address wrong");
    indexed_addr_a:
        assert property (go && instr_i[15:12] == 4'h8 && ext_en_i
            && !instr_i[8] && instr_i[7:0] <= 8'h5f |=> indexed_o
            && mem_o.addr == index_i + {4'h0, instr_i[7:0]})
        else $error("indexed address wrong");
    skip_clr_a:
        assert property (quarter_o == 4'h2 && !flush_o
            && instr_i[15:12] == 4'hb && !mem_rdata_i[instr_i[11:9]]
            |-> ##3 skip_o && flush_o) else $error("clear skip missed");
    skip_set_a:
        assert property (quarter_o == 4'h2 && !flush_o
            && instr_i[15:12] == 4'ha && mem_rdata_i[instr_i[11:9]]
            |-> ##3 skip_o && flush_o) else $error("set skip missed");
    flush_quiet_a:
        assert property (flush_o |-> !mem_o.wr)
        else $error("write in flushed cycle");
    status_keep_a:
        assert property (!status_we_o) else $error("status written");
    // Main scenarios reached
    cover property (jump_o);
    cover property (skip_o);
    cover property (mem_o.wr);
    cover property (indexed_o);
endmodule

bind bbx_exec bbx_exec_chk i_bbx_exec_chk (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .instr_i(instr_i),
    .bank_i(bank_i), .ext_en_i(ext_en_i), .index_i(index_i),
    .indexed_o(indexed_o), .mem_rdata_i(mem_rdata_i), .mem_o(mem_o),
    .pc_o(pc_o), .quarter_o(quarter_o), .flush_o(flush_o),
    .skip_o(skip_o), .jump_o(jump_o), .status_we_o(status_we_o));

//--- tb/tb.sv
/* Self-checking bench for bbx_exec. Feeds one word per instruction
   cycle and plays the file memory; expects lockstep after reset. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              core_clk_i, rstn_i, ext_en_i, cycle_end_o;
    logic              flush_o, skip_o, jump_o, indexed_o, status_we_o;
    logic [15:0]       instr_i;
    logic [3:0]        bank_i, quarter_o, g_f;
    logic [11:0]       index_i;
    logic [7:0]        mem_rdata_i;
    logic [20:0]       pc_o, pc0, pc1;
    bbx_pkg::bbx_mem_t mem_o, g_q2, g_q4;
    int                n_fail, comparisons;
    logic [15:0]       jw[4] = '{16'hd003, 16'hd7ff, 16'hd3ff, 16'hd400};

    bbx_exec i_bbx_exec (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .instr_i(instr_i), .bank_i(bank_i), .ext_en_i(ext_en_i),
        .index_i(index_i), .mem_rdata_i(mem_rdata_i), .mem_o(mem_o),
        .pc_o(pc_o), .quarter_o(quarter_o), .cycle_end_o(cycle_end_o),
        .flush_o(flush_o), .skip_o(skip_o), .jump_o(jump_o),
        .indexed_o(indexed_o), .status_we_o(status_we_o));

    // 125 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    function automatic logic [15:0] w(logic [3:0] op, logic [2:0] b,
                                      logic a, logic [7:0] f);
        return {op, b, a, f};
    endfunction

    task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One instruction cycle; captures Q2 and Q4 views and the new pc
    task automatic cyc(logic [15:0] word, logic [7:0] rd);
        instr_i = word;
        mem_rdata_i = rd;
        pc0 = pc_o;
        @(posedge core_clk_i) #1;
        g_q2 = mem_o;
        chk("quarter", 4'h2, quarter_o);
        g_f = {flush_o, skip_o, jump_o, indexed_o};
        repeat (2) @(posedge core_clk_i) #1;
        g_q4 = mem_o;
        chk("cycle end", 1'b1, cycle_end_o);
        @(posedge core_clk_i) #1;
        pc1 = pc_o;
    endtask

    task automatic t_force();
        cyc(w(4'h8, 3'h7, 1'b0, 8'h05), 8'h0a);
        chk("low access addr", 12'h005, g_q2.addr);
        chk("read strobe", 1'b1, g_q2.rd);
        chk("write strobe", 1'b1, g_q4.wr);
        chk("force data", 8'h8a, g_q4.wdata);
        cyc(w(4'h8, 3'h0, 1'b1, 8'h34), 8'hfe);
        chk("banked addr", 12'h334, g_q2.addr);
        chk("force data", 8'hff, g_q4.wdata);
        cyc(w(4'h8, 3'h3, 1'b0, 8'h80), 8'h00);
        chk("high access addr", 12'hf80, g_q2.addr);
        chk("force data", 8'h08, g_q4.wdata);
    endtask

    // Window edge at 0x5f versus 0x60, and a=1 stays banked
    task automatic t_index();
        ext_en_i = 1'b1;
        index_i = 12'h100;
        cyc(w(4'h8, 3'h1, 1'b0, 8'h5f), 8'h00);
        chk("indexed addr", 12'h15f, g_q2.addr);
        chk("indexed flag", 1'b1, g_f[0]);
        cyc(w(4'h8, 3'h1, 1'b0, 8'h60), 8'h00);
        chk("past window addr", 12'hf60, g_q2.addr);
        chk("indexed flag", 1'b0, g_f[0]);
        cyc(w(4'h8, 3'h1, 1'b1, 8'h10), 8'h00);
        chk("banked addr", 12'h310, g_q2.addr);
        ext_en_i = 1'b0;
    endtask

    // Offsets +3, -1, max and min; a write in the refill slot is dropped
    task automatic t_jump();
        foreach (jw[i]) begin
            cyc(jw[i], 8'h00);
            chk("jump pc", pc0 + 21'h2
                + {{9{jw[i][10]}}, jw[i][10:0], 1'b0}, pc1);
            cyc(w(4'h8, 3'h0, 1'b1, 8'h01), 8'h00);
            chk("refill write", 1'b0, g_q4.wr);
            chk("jump flag", 1'b1, g_f[1]);
            chk("refill flush", 1'b1, g_f[3]);
        end
        cyc(16'hd800, 8'h00);
        chk("not a jump pc", pc0 + 21'h2, pc1);
        cyc(16'h0000, 8'h00);
        chk("no jump flag", 1'b0, g_f[1]);
    endtask

    // Both test kinds against bit 5 clear and set
    task automatic t_skip();
        for (int i = 0; i < 4; i++) begin
            cyc(w(i[1] ? 4'ha : 4'hb, 3'h5, 1'b1, 8'h20),
                i[0] ? 8'h20 : 8'hdf);
            chk("test write", 1'b0, g_q4.wr);
            cyc(w(4'h8, 3'h0, 1'b1, 8'h21), 8'h00);
            chk("skip flag", i[1] == i[0], g_f[2]);
            chk("nop write", i[1] != i[0], g_q4.wr);
        end
        chk("status write", 1'b0, status_we_o);
    endtask

    task automatic close_out();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after a five-cycle reset
    initial begin
        {rstn_i, ext_en_i, instr_i, index_i, mem_rdata_i} = '0;
        bank_i = 4'h3;
        repeat (5) @(posedge core_clk_i);
        #1 rstn_i = 1'b1;
        t_force();
        t_index();
        t_jump();
        t_skip();
        close_out();
    end

    // Run needs about 100 cycles; fifteen times that means a hang
    initial begin
        #12000;
        n_fail++;
        close_out();
    end
endmodule
